// >>> rtl/ch2_cfg_pkg.sv
// Constants and types shared by the channel 2 configuration block
package ch2_cfg_pkg;
  // Register map of the serial port
  localparam logic [7:0]  CH2_EN_DIS_ADDR  = 8'h2E;   // channel2_enable_discharge
  localparam int          ADE_POS          = 3;       // Active discharge enable bit
  localparam int          EN_MSB           = 2;       // Enable field high bit
  localparam int          EN_LSB           = 0;       // Enable field low bit
  localparam logic [3:0]  BLANK_READ       = 4'h0;    // Unimplemented bits 7:4 read value
  localparam logic [3:0]  CFG_RST          = 4'h0;    // Flop value before the defaults load
  localparam logic [7:0]  UNMAPPED_READ    = 8'h00;   // Answer for other register offsets
  localparam logic [3:0]  BITS_PER_BYTE    = 4'h8;
  // Enable field mode prefixes (bits 2:1)
  localparam logic [1:0]  EN_FORCE_OFF     = 2'h2;
  localparam logic [1:0]  EN_FORCE_ON      = 2'h3;
  // Target voltage transfer functions, millivolts
  localparam logic [12:0] LOW_BASE_MV      = 13'h0320;  // 800 mV at code zero
  localparam logic [12:0] HIGH_BASE_MV     = 13'h0960;  // 2400 mV at code zero
  localparam logic [12:0] STEP_MV          = 13'h0032;  // 50 mV per code
  localparam logic [5:0]  HIGH_MAX_CODE    = 6'h39;     // Last legal code, high variant

  typedef enum logic [6:0] {
    ST_IDLE     = 7'b0000001,
    ST_ADDR     = 7'b0000010,
    ST_ADDR_ACK = 7'b0000100,
    ST_RX       = 7'b0001000,
    ST_RX_ACK   = 7'b0010000,
    ST_TX       = 7'b0100000,
    ST_TX_ACK   = 7'b1000000
  } ser_state_t;

  // Output millivolts for a code on either variant
  function automatic logic [12:0] code_to_mv(input logic [5:0] code, input logic high_var);
    logic [12:0] base;
    base = high_var ? HIGH_BASE_MV : LOW_BASE_MV;
    return 13'(base + 13'(13'(code) * STEP_MV));
  endfunction : code_to_mv
endpackage : ch2_cfg_pkg

// >>> rtl/vsel_if.sv
// Carrier between the configuration top and the voltage code mapper
`timescale 1ns/1ps
`default_nettype none
interface vsel_if;
  logic [5:0]  code;          // Target voltage code
  logic        high_variant;  // Higher voltage variant selected
  logic [12:0] mv;            // Mapped output in millivolts
  logic        reserved;      // Code is reserved on this variant
  modport user   (output code, output high_variant, input mv, input reserved);
  modport mapper (input code, input high_variant, output mv, output reserved);
endinterface : vsel_if
`default_nettype wire

// >>> rtl/ch2_vsel_map.sv
// Target voltage code to millivolt mapping for both device variants
`timescale 1ns/1ps
`default_nettype none
module ch2_vsel_map
  import ch2_cfg_pkg::*;
(
  vsel_if.mapper vs  // Code in, millivolts out
);
  // Linear on both variants; high variant tops out early
  assign vs.mv       = code_to_mv(vs.code, vs.high_variant);
  assign vs.reserved = vs.high_variant && (vs.code > HIGH_MAX_CODE);
endmodule : ch2_vsel_map
`default_nettype wire

// >>> rtl/buck_boost_ch2_config.sv
// Channel 2 enable, discharge and target voltage configuration behind the serial register port
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - On the lower-voltage variant the code maps to 0.80 V plus 50 mV per step, 3.95 V at all ones.
// - On the higher-voltage variant the code maps to 2.40 V plus 50 mV per step, 5.25 V at 0x39.
// - Bits 7 to 4 of the enable register do not exist; software writes zero and reads mean nothing.
// - Bit 3 set puts the discharge resistor on the output while the channel is off; clear, never.
// - Enable codes 000 to 011 make the channel follow power sequencer slot 0 to 3.
// - Enable codes 100 and 101 hold the channel off whatever the sequencer does.
// - Enable codes 110 and 111 turn the channel on whenever the on/off controller is in an on state.
module buck_boost_ch2_config
  import ch2_cfg_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h2A  // Serial address; value is arbitrary
) (
  input  wire logic        clk,                       // 100 MHz clock
  input  wire logic        arst_n,                    // Async reset, active low
  input  wire logic        scl,                       // Serial clock pin
  input  wire logic        sda_in,                    // Serial data pin level
  output var  logic        sda_out,                   // Serial data drive value, always low
  output var  logic        sda_oe,                    // Pull serial data low
  input  wire logic        system_reset_event,        // One-cycle system reset pulse
  input  wire logic [3:0]  otp_ch2_defaults,          // Factory defaults for bits 3:0
  input  wire logic        high_voltage_variant,      // Variant strap pin
  input  wire logic [5:0]  ch2_target_voltage_code,   // Target code from config logic
  input  wire logic [3:0]  power_sequencer_slot_on,   // Per-slot on state of sequencer
  input  wire logic        onoff_ctrl_on,             // Controller in software-on or controller-on
  output var  logic        ch2_on,                    // Channel regulating
  output var  logic        ch2_discharge_on,          // Discharge resistor switched in
  output var  logic [12:0] ch2_target_mv,             // Target output in millivolts
  output var  logic        ch2_code_reserved,         // Reserved code programmed
  output var  logic        ch2_active_discharge_en,   // Register bit 3
  output var  logic [2:0]  ch2_enable_ctrl            // Register bits 2:0
);
  // Pin synchronisers; first stages are read by the second only
  logic scl_meta, scl_s, scl_d, sda_meta, sda_s, sda_d, var_meta, var_s;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {scl_meta, scl_s, scl_d} <= 3'h7;
      {sda_meta, sda_s, sda_d} <= 3'h7;
      {var_meta, var_s}        <= 2'h0;
    end else begin
      {scl_meta, scl_s, scl_d} <= {scl, scl_meta, scl_s};
      {sda_meta, sda_s, sda_d} <= {sda_in, sda_meta, sda_s};
      {var_meta, var_s}        <= {high_voltage_variant, var_meta};
    end
  end

  // Bus events from the synchronised levels
  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;
  wire start_ev = scl_s && scl_d && !sda_s && sda_d;
  wire stop_ev  = scl_s && scl_d && sda_s && !sda_d;

  ser_state_t state;
  logic [3:0] bitcnt;
  logic [7:0] shreg, tx_sh, ptr;
  logic       first;
  logic       otp_loaded;

  // Decoding of the serial engine
  wire       byte_done  = scl_fall && (bitcnt == BITS_PER_BYTE);
  wire       addr_match = (shreg[7:1] == SLAVE_ADDR);
  wire       ptr_hit    = (ptr == CH2_EN_DIS_ADDR);
  wire       wr_strobe  = (state == ST_RX) && byte_done && !first && ptr_hit;
  wire [7:0] rd_byte    = ptr_hit ? {BLANK_READ, ch2_active_discharge_en, ch2_enable_ctrl}
                                  : UNMAPPED_READ;

  // Serial slave engine; start and stop override any state so a broken frame recovers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state  <= ST_IDLE;
      bitcnt <= 4'h0;
      shreg  <= 8'h00;
      tx_sh  <= 8'h00;
      ptr    <= 8'h00;
      first  <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_ev) begin
      state  <= ST_ADDR;
      bitcnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_ev) begin
      state  <= ST_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            shreg  <= {shreg[6:0], sda_s};
            bitcnt <= 4'(bitcnt + 4'h1);
          end else if (byte_done) begin
            if (state == ST_ADDR && !addr_match) begin
              state <= ST_IDLE;
            end else begin
              state  <= (state == ST_ADDR) ? ST_ADDR_ACK : ST_RX_ACK;
              sda_oe <= 1'b1;
            end
            if (state == ST_RX && first) begin
              ptr <= shreg;
            end
            if (state == ST_RX) begin
              first <= 1'b0;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            bitcnt <= 4'h0;
            if (shreg[0]) begin
              state  <= ST_TX;
              tx_sh  <= rd_byte;
              sda_oe <= ~rd_byte[7];
            end else begin
              state  <= ST_RX;
              first  <= 1'b1;
              sda_oe <= 1'b0;
            end
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            state  <= ST_RX;
            bitcnt <= 4'h0;
            sda_oe <= 1'b0;
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            tx_sh  <= {tx_sh[6:0], 1'b0};
            bitcnt <= 4'(bitcnt + 4'h1);
          end else if (byte_done) begin
            state  <= ST_TX_ACK;
            sda_oe <= 1'b0;
          end else if (scl_fall) begin
            sda_oe <= ~tx_sh[7];
          end
        end
        ST_TX_ACK: begin
          if (scl_rise && sda_s) begin
            state <= ST_IDLE;  // Master NACK ends the read
          end else if (scl_fall) begin
            state  <= ST_TX;
            bitcnt <= 4'h0;
            tx_sh  <= rd_byte;
            sda_oe <= ~rd_byte[7];
          end
        end
        default: begin
          state  <= ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Open drain: the level driven is always low, only the enable moves
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) sda_out <= 1'b0;
    else         sda_out <= 1'b0;
  end

  // Defaults cannot be taken under async reset, so they load on the first edge after release
  wire load_otp = system_reset_event || !otp_loaded;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      otp_loaded              <= 1'b0;
      ch2_active_discharge_en <= CFG_RST[ADE_POS];
      ch2_enable_ctrl         <= CFG_RST[EN_MSB:EN_LSB];
    end else if (load_otp) begin
      otp_loaded              <= 1'b1;
      ch2_active_discharge_en <= otp_ch2_defaults[ADE_POS];
      ch2_enable_ctrl         <= otp_ch2_defaults[EN_MSB:EN_LSB];
    end else if (wr_strobe) begin
      // Upper bits of the written byte have no storage and are dropped
      ch2_active_discharge_en <= shreg[ADE_POS];
      ch2_enable_ctrl         <= shreg[EN_MSB:EN_LSB];
    end
  end

  // Channel on/off decision from the enable field
  wire slot_mode    = !ch2_enable_ctrl[EN_MSB];
  wire slot_state   = power_sequencer_slot_on[ch2_enable_ctrl[EN_MSB-1:EN_LSB]];
  wire forced_on    = (ch2_enable_ctrl[EN_MSB:EN_LSB+1] == EN_FORCE_ON) && onoff_ctrl_on;
  wire next_on      = slot_mode ? slot_state : forced_on;
  wire next_dischg  = ch2_active_discharge_en && !next_on;

  // Voltage mapping through the small mapper
  vsel_if vs ();
  assign vs.code         = ch2_target_voltage_code;
  assign vs.high_variant = var_s;
  ch2_vsel_map u_map (
    .vs (vs.mapper)
  );

  // Registered channel outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ch2_on            <= 1'b0;
      ch2_discharge_on  <= 1'b0;
      ch2_target_mv     <= LOW_BASE_MV;
      ch2_code_reserved <= 1'b0;
    end else begin
      ch2_on            <= next_on;
      ch2_discharge_on  <= next_dischg;
      ch2_target_mv     <= vs.mv;
      ch2_code_reserved <= vs.reserved;
    end
  end

  // Reject addresses in the reserved low group
  if (SLAVE_ADDR < 7'h08) begin : g_addr_chk
    $error("SLAVE_ADDR falls in the reserved address group");
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence en_mode(logic [1:0] m);
    ch2_enable_ctrl[EN_MSB:EN_LSB+1] == m;
  endsequence
  sequence slot_live;
    !ch2_enable_ctrl[EN_MSB] && power_sequencer_slot_on[ch2_enable_ctrl[EN_MSB-1:EN_LSB]];
  endsequence

  AST_SLOT_FOLLOW: assert property (slot_live |=> ch2_on)
    else $error("channel not on while its sequencer slot is on");
  AST_SLOT_DROP: assert property (!ch2_enable_ctrl[EN_MSB]
                                  && !power_sequencer_slot_on[ch2_enable_ctrl[EN_MSB-1:EN_LSB]] |=> !ch2_on)
    else $error("channel on while its sequencer slot is off");
  AST_FORCE_OFF: assert property (en_mode(EN_FORCE_OFF) |=> !ch2_on)
    else $error("channel on under a force-off code");
  AST_FORCE_ON: assert property (en_mode(EN_FORCE_ON) ##0 onoff_ctrl_on |=> ch2_on)
    else $error("channel off under force-on with controller on");
  AST_FORCE_GATE: assert property (en_mode(EN_FORCE_ON) ##0 !onoff_ctrl_on |=> !ch2_on)
    else $error("channel on under force-on with controller off");
  AST_DISCHARGE: assert property (ch2_active_discharge_en && !next_on |=> ch2_discharge_on && !ch2_on)
    else $error("discharge resistor missing while channel off");
  AST_NO_DISCHARGE: assert property (ch2_discharge_on |-> !ch2_on && $past(ch2_active_discharge_en))
    else $error("discharge resistor applied without enable or while on");
  AST_LOW_MAP: assert property (!var_s ##1 !var_s |-> ch2_target_mv ==
                                13'(LOW_BASE_MV + 13'(13'($past(ch2_target_voltage_code)) * STEP_MV)))
    else $error("low variant millivolt mapping wrong");
  AST_HIGH_MAP: assert property (var_s ##1 var_s |-> ch2_target_mv ==
                                 13'(HIGH_BASE_MV + 13'(13'($past(ch2_target_voltage_code)) * STEP_MV)))
    else $error("high variant millivolt mapping wrong");
  AST_RESERVED: assert property (var_s && ch2_target_voltage_code > HIGH_MAX_CODE |=> ch2_code_reserved)
    else $error("reserved code not flagged");
  AST_SYSTEM_RESET_EVENT_LOAD: assert property (system_reset_event |=>
                                    {ch2_active_discharge_en, ch2_enable_ctrl} == $past(otp_ch2_defaults))
    else $error("defaults not reloaded on system reset");
endmodule : buck_boost_ch2_config
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for the channel 2 configuration block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ch2_cfg_pkg::*;
  localparam logic [6:0] DEV_ADDR = 7'h2A;  // Serial address; value is arbitrary
  typedef struct {int sel; logic [15:0] val;} note_t;
  logic        clk, arst_n, scl, sda_m, sys_rst, high_var, onoff;
  logic [3:0]  otp, slots;
  logic [5:0]  tv_code;
  logic        sda_oe, sda_out, ch2_on, dis_on, rsv, ade;
  logic [12:0] tmv;
  logic [2:0]  en;
  logic [7:0]  rd_byte;
  wire logic   sda_line;
  int          miscompares, checks;
  note_t       notes[$];
  event        chk_ev;

  // Open drain line: the device or the master pulls low, the pull-up wins otherwise
  assign sda_line = sda_m & (sda_oe ? sda_out : 1'b1);

  buck_boost_ch2_config #(.SLAVE_ADDR(DEV_ADDR)) dut (
    .clk(clk), .arst_n(arst_n), .scl(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .system_reset_event(sys_rst), .otp_ch2_defaults(otp), .high_voltage_variant(high_var),
    .ch2_target_voltage_code(tv_code), .power_sequencer_slot_on(slots), .onoff_ctrl_on(onoff),
    .ch2_on(ch2_on), .ch2_discharge_on(dis_on), .ch2_target_mv(tmv), .ch2_code_reserved(rsv),
    .ch2_active_discharge_en(ade), .ch2_enable_ctrl(en));

  // Free running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_clk

  task automatic compare(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      miscompares++;
    end
  endtask : compare

  task automatic results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  // Post an expectation; the clock edge keeps two posts apart
  task automatic note(input int sel, input logic [15:0] val);
    notes.push_back('{sel, val});
    ->chk_ev;
    @(posedge clk);
  endtask : note

  // One serial bit, slow enough for the 2-flop synchronisers
  task automatic ser_bit(input logic b, output logic r);
    sda_m <= b;
    wait_clk(8);
    scl <= 1'b1;
    wait_clk(6);
    r = sda_line;
    wait_clk(2);
    scl <= 1'b0;
    wait_clk(8);
  endtask : ser_bit

  // Byte MSB first; the ninth bit is always released (device ACK or master NACK)
  task automatic ser_byte(input logic [7:0] tx, output logic [7:0] rx);
    logic ack;
    for (int i = 7; i >= 0; i--) ser_bit(tx[i], rx[i]);
    ser_bit(1'b1, ack);
  endtask : ser_byte

  // Data rises before the clock so no false stop is seen on a repeated start
  task automatic ser_start();
    sda_m <= 1'b1;
    wait_clk(8);
    scl <= 1'b1;
    wait_clk(8);
    sda_m <= 1'b0;
    wait_clk(8);
    scl <= 1'b0;
    wait_clk(8);
  endtask : ser_start

  task automatic ser_stop();
    sda_m <= 1'b0;
    wait_clk(8);
    scl <= 1'b1;
    wait_clk(8);
    sda_m <= 1'b1;
    wait_clk(8);
  endtask : ser_stop

  task automatic reg_wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] data);
    logic [7:0] rx;
    ser_start();
    ser_byte({dev, 1'b0}, rx);
    ser_byte(ptr, rx);
    ser_byte(data, rx);
    ser_stop();
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] ptr);
    logic [7:0] rx;
    ser_start();
    ser_byte({DEV_ADDR, 1'b0}, rx);
    ser_byte(ptr, rx);
    ser_start();
    ser_byte({DEV_ADDR, 1'b1}, rx);
    ser_byte(8'hFF, rd_byte);
    ser_stop();
  endtask : reg_rd

  // Watcher: takes each posted note and compares it with the outputs
  initial begin
    note_t n;
    logic [15:0] seen;
    forever begin
      @(chk_ev);
      // Look between edges so the outputs launched by the last edge have settled
      @(negedge clk);
      while (notes.size() > 0) begin
        n = notes.pop_front();
        case (n.sel)
          0: seen = {2'h0, rsv, tmv};
          1: seen = {14'h0, ch2_on, dis_on};
          2: seen = {8'h0, rd_byte};
          default: seen = {12'h0, ade, en};
        endcase
        compare(seen, n.val);
      end
    end
  end

  // Watchdog: the tests need about 30k cycles, so 60k means a hang
  initial begin
    #600_000;
    miscompares++;
    results();
  end

  // Main sequence
  initial begin
    logic [5:0] edges[4] = '{6'h00, 6'h39, 6'h3A, 6'h3F};
    logic [7:0] d;
    logic [5:0] c;
    logic       v, on_x;
    logic [3:0] smask;
    arst_n = 1'b0; scl = 1'b1; sda_m = 1'b1; sys_rst = 1'b0; high_var = 1'b0;
    onoff = 1'b0; slots = 4'h0; tv_code = 6'h00; checks = 0; miscompares = 0;
    void'($urandom(73287));
    otp = 4'($urandom());
    wait_clk(5);
    arst_n <= 1'b1;
    wait_clk(3);
    note(3, {12'h0, otp});
    // Both variants at the edge codes, then random codes
    for (int k = 0; k < 24; k++) begin
      v = k[0];
      c = (k < 8) ? edges[k >> 1] : 6'($urandom());
      if (k >= 8 && v && c > HIGH_MAX_CODE) c = 6'(c - 6'h06);
      high_var <= v;
      tv_code <= c;
      wait_clk(6);
      note(0, {2'h0, v && c > 6'h39, (v ? 13'h0960 : 13'h0320) + 13'(c) * 13'h0032});
    end
    // Every enable code twice; the second pass flips the slot states and the controller state
    smask = 4'($urandom());
    for (int k = 0; k < 16; k++) begin
      d = 8'($urandom());
      d[7:4] = 4'h0;
      d[2:0] = 3'(k);
      slots <= smask ^ {4{k[3]}};
      onoff <= k[3];
      // Bias circuits sit outside this block and are taken to be in normal power mode here
      reg_wr(DEV_ADDR, CH2_EN_DIS_ADDR, d);
      wait_clk(4);
      on_x = d[2] ? (d[1] & onoff) : slots[d[1:0]];
      note(3, {12'h0, d[3:0]});
      note(1, {14'h0, on_x, d[3] & ~on_x});
      reg_rd(CH2_EN_DIS_ADDR);
      note(2, {12'h0, d[3:0]});
    end
    // Unmapped offset and a foreign device address leave the register alone
    reg_wr(DEV_ADDR, 8'h2D, ~d);
    reg_wr(DEV_ADDR ^ 7'h01, CH2_EN_DIS_ADDR, ~d);
    note(3, {12'h0, d[3:0]});
    reg_rd(8'h2D);
    note(2, {8'h0, UNMAPPED_READ});
    // System reset event reloads the factory defaults
    otp <= ~d[3:0];
    wait_clk(1);
    sys_rst <= 1'b1;
    wait_clk(1);
    sys_rst <= 1'b0;
    wait_clk(2);
    note(3, {12'h0, otp});
    // Second asynchronous reset in mid-run
    otp <= 4'($urandom());
    arst_n <= 1'b0;
    wait_clk(2);
    arst_n <= 1'b1;
    wait_clk(3);
    note(3, {12'h0, otp});
    results();
  end
endmodule : testbench
`default_nettype wire
